/* hdl/pmrc_params.svh */
/*
 * Constants of the power mode and reset controller: frame layout, channel
 * positions, synchroniser bus positions, reset values and timing.
 * Assumes inclusion by the package and the design files by bare name.
 */
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH

`define PMRC_FRAME_BITS 16
`define PMRC_CNT_W 5
`define PMRC_CNT_LOAD 5'h00
`define PMRC_CNT_LAST 5'h0F
`define PMRC_CNT_FULL 5'h10
`define PMRC_CNT_STEP 5'h01
`define PMRC_STATUS_W 8
`define PMRC_STATUS_PAD 8'h00
`define PMRC_CHAN_NUM 8
`define PMRC_CHAN_RST 8'h00
`define PMRC_CHAN_A 3
`define PMRC_CHAN_B 4
`define PMRC_PIN_W 6
`define PMRC_PIN_BAT_UV 0
`define PMRC_PIN_DD_UV 1
`define PMRC_PIN_FS 2
`define PMRC_PIN_IN1 3
`define PMRC_PIN_IN2 4
`define PMRC_PIN_TOG 5
`define PMRC_CLOCK_MHZ 100
`define PMRC_WAKEUP_DELAY_US 200
`define PMRC_WAKE_CNT_W 16

`endif

/* hdl/pmrc_pkg.sv */
/*
 * Types of the power mode and reset controller: states, command frame and
 * status frame.
 * Assumes pmrc_params.svh is on the include path.
 */
`default_nettype none
`include "pmrc_params.svh"

package pmrc_pkg;

	typedef enum logic [3:0] {
		PMRC_ST_STANDBY = 4'h1,
		PMRC_ST_WAKEUP = 4'h2,
		PMRC_ST_OPERATE = 4'h4,
		PMRC_ST_FAILSAFE = 4'h8
	} pmrc_state_t;

	typedef struct packed {
		logic [4:0] spare;
		logic resetCmd;
		logic standbyCmd;
		logic wakeCmd;
		logic [`PMRC_CHAN_NUM-1:0] chan;
	} pmrc_frame_t;

	typedef struct packed {
		logic transferFault;
		logic failsafe;
		logic operating;
		logic waking;
		logic uvReset;
		logic frameIgnored;
		logic [1:0] spare;
	} pmrc_status_t;

endpackage

`default_nettype wire

/* hdl/pmrc_sync.sv */
/*
 * Two flip-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a level that stays put for several destination clocks.
 */
`default_nettype none

module pmrc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end

endmodule // pmrc_sync

`default_nettype wire

/* hdl/pmrc_power_mode_reset_control.sv */
/*
 * Power mode, reset and fail-safe control of a serially driven relay switch,
 * with the serial shift path on the link clock.
 * Assumes supply monitors give undervoltage levels, the fail-safe and direct
 * inputs are asynchronous pins, and the link clock only runs in frames.
 */
`default_nettype none
`include "pmrc_params.svh"

module pmrc_power_mode_reset_control
	import pmrc_pkg::*;
#(
	parameter int WAKEUP_CYCLES = `PMRC_WAKEUP_DELAY_US * `PMRC_CLOCK_MHZ
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic batteryUv,
	input wire logic logicUv,
	input wire logic failsafe_input,
	input wire logic directIn1,
	input wire logic directIn2,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output logic spiSo,
	output logic spiSoOe,
	output logic [`PMRC_CHAN_NUM-1:0] chanOut,
	output logic deviceOn,
	output logic failsafeActive,
	output logic transfer_fault_flag,
	output logic uvResetActive,
	output logic frameIgnored
);

	localparam logic [`PMRC_WAKE_CNT_W-1:0] WAKE_LOAD = `PMRC_WAKE_CNT_W'(WAKEUP_CYCLES - 1);
	localparam logic [`PMRC_WAKE_CNT_W-1:0] WAKE_ONE = `PMRC_WAKE_CNT_W'(1);

	// ****************************************************************
	// Link domain: shift register and frame capture
	// ****************************************************************

	logic [`PMRC_CNT_W-1:0] bitCnt;
	logic [`PMRC_CNT_W-1:0] next_bitCnt;
	logic [`PMRC_FRAME_BITS-1:0] shiftReg;
	logic [`PMRC_FRAME_BITS-1:0] next_shiftReg;
	logic [`PMRC_FRAME_BITS-1:0] rxWord;
	logic [`PMRC_FRAME_BITS-1:0] next_rxWord;
	logic rxToggle;
	logic next_rxToggle;
	logic next_spiSo;
	logic [`PMRC_STATUS_W-1:0] statusSys;
	logic [`PMRC_STATUS_W-1:0] statusLink;
	logic [`PMRC_FRAME_BITS-1:0] loaded;

	// The status word is sampled on the link clock; since that clock stops
	// between frames, a reply may show the state of the previous frame.
	pmrc_sync #(
		.WIDTH(`PMRC_STATUS_W)
	) u_status_sync (
		.clk(spiClk),
		.rst(sys_rst),
		.din(statusSys),
		.dout(statusLink)
	);

	// The status word takes the place of the shift register at the first edge
	// of a frame; every later bit only passes through.
	always_comb begin
		loaded = shiftReg;
		if (bitCnt == `PMRC_CNT_LOAD) begin
			loaded = {statusLink, `PMRC_STATUS_PAD};
		end
		next_shiftReg = {loaded[`PMRC_FRAME_BITS-2:0], spiMosi};
		next_spiSo = loaded[`PMRC_FRAME_BITS-1];
		next_bitCnt = bitCnt;
		if (bitCnt != `PMRC_CNT_FULL) begin
			next_bitCnt = bitCnt + `PMRC_CNT_STEP;
		end
		next_rxWord = rxWord;
		next_rxToggle = rxToggle;
		if (bitCnt == `PMRC_CNT_LAST) begin
			next_rxWord = next_shiftReg;
			next_rxToggle = ~rxToggle;
		end
	end

	// The bit counter and the output enable end with the frame itself.
	always_ff @(posedge spiClk or posedge spiCsN) begin
		if (spiCsN) begin
			bitCnt <= `PMRC_CNT_LOAD;
			spiSoOe <= 1'b0;
		end else begin
			bitCnt <= next_bitCnt;
			spiSoOe <= 1'b1;
		end
	end

	// Bits beyond the first frame pass through to the serial output.
	always_ff @(posedge spiClk or posedge sys_rst) begin
		if (sys_rst) begin
			shiftReg <= '0;
			spiSo <= 1'b0;
			rxWord <= '0;
			rxToggle <= 1'b0;
		end else begin
			shiftReg <= next_shiftReg;
			spiSo <= next_spiSo;
			rxWord <= next_rxWord;
			rxToggle <= next_rxToggle;
		end
	end

	// ****************************************************************
	// System domain: pin synchronisers and frame arrival
	// ****************************************************************

	logic [`PMRC_PIN_W-1:0] pinRaw;
	logic [`PMRC_PIN_W-1:0] pinSync;
	logic batUvS;
	logic logicUvS;
	logic fsS;
	logic in1S;
	logic in2S;
	logic togSeen;
	logic frameStrobe;
	pmrc_frame_t frame;

	always_comb begin
		pinRaw = '0;
		pinRaw[`PMRC_PIN_BAT_UV] = batteryUv;
		pinRaw[`PMRC_PIN_DD_UV] = logicUv;
		pinRaw[`PMRC_PIN_FS] = failsafe_input;
		pinRaw[`PMRC_PIN_IN1] = directIn1;
		pinRaw[`PMRC_PIN_IN2] = directIn2;
		pinRaw[`PMRC_PIN_TOG] = rxToggle;
	end

	pmrc_sync #(
		.WIDTH(`PMRC_PIN_W)
	) u_pin_sync (
		.clk(clock),
		.rst(sys_rst),
		.din(pinRaw),
		.dout(pinSync)
	);

	assign batUvS = pinSync[`PMRC_PIN_BAT_UV];
	assign logicUvS = pinSync[`PMRC_PIN_DD_UV];
	assign fsS = pinSync[`PMRC_PIN_FS];
	assign in1S = pinSync[`PMRC_PIN_IN1];
	assign in2S = pinSync[`PMRC_PIN_IN2];
	assign frameStrobe = pinSync[`PMRC_PIN_TOG] ^ togSeen;
	// The captured word stays still until the next frame completes.
	assign frame = pmrc_frame_t'(rxWord);

	// ****************************************************************
	// System domain: mode, reset and channel control
	// ****************************************************************

	pmrc_state_t state;
	pmrc_state_t next_state;
	logic [`PMRC_CHAN_NUM-1:0] chanReg;
	logic [`PMRC_CHAN_NUM-1:0] next_chanReg;
	logic [`PMRC_CHAN_NUM-1:0] next_chanOut;
	logic [`PMRC_WAKE_CNT_W-1:0] wakeCnt;
	logic [`PMRC_WAKE_CNT_W-1:0] next_wakeCnt;
	logic next_transferFault;
	logic next_uvReset;
	logic next_frameIgnored;
	logic next_deviceOn;
	logic next_failsafeActive;
	logic resetEvent;

	always_comb begin
		next_state = state;
		next_chanReg = chanReg;
		next_wakeCnt = wakeCnt;
		next_transferFault = transfer_fault_flag;
		next_frameIgnored = frameIgnored;
		next_uvReset = uvResetActive;
		resetEvent = 1'b0;
		// Only battery undervoltage starts the reset; a missing logic supply
		// alone holds the reset flag as it is.
		if (batUvS) begin
			next_uvReset = 1'b1;
		end else if (!logicUvS) begin
			next_uvReset = 1'b0;
		end
		if (next_uvReset) begin
			resetEvent = 1'b1;
		end else if (fsS) begin
			// Fail-safe entry resets the write registers, so like any other reset
			// it raises the fault flag; frames inside it are only marked dropped.
			next_state = PMRC_ST_FAILSAFE;
			next_chanReg = `PMRC_CHAN_RST;
			next_transferFault = 1'b1;
			if (frameStrobe) begin
				next_frameIgnored = 1'b1;
			end
		end else begin
			case (state)
				PMRC_ST_FAILSAFE: begin
					next_state = PMRC_ST_STANDBY;
					next_chanReg = `PMRC_CHAN_RST;
				end
				PMRC_ST_WAKEUP: begin
					if (frameStrobe) begin
						next_frameIgnored = 1'b1;
					end
					if (wakeCnt == '0) begin
						next_state = PMRC_ST_OPERATE;
					end else begin
						next_wakeCnt = wakeCnt - WAKE_ONE;
					end
				end
				PMRC_ST_STANDBY: begin
					if (frameStrobe) begin
						next_frameIgnored = 1'b0;
						next_transferFault = 1'b0;
						if (frame.resetCmd) begin
							resetEvent = 1'b1;
						end else if (frame.wakeCmd) begin
							next_state = PMRC_ST_WAKEUP;
							next_wakeCnt = WAKE_LOAD;
						end
					end
				end
				PMRC_ST_OPERATE: begin
					if (frameStrobe) begin
						next_frameIgnored = 1'b0;
						next_transferFault = 1'b0;
						if (frame.resetCmd) begin
							resetEvent = 1'b1;
						end else if (frame.standbyCmd) begin
							next_state = PMRC_ST_STANDBY;
							next_chanReg = `PMRC_CHAN_RST;
						end else begin
							next_chanReg = frame.chan;
						end
					end
				end
				default: begin
					resetEvent = 1'b1;
				end
			endcase
		end
		// A reset in the same cycle as a clearing frame leaves the flag set.
		if (resetEvent) begin
			next_state = PMRC_ST_STANDBY;
			next_chanReg = `PMRC_CHAN_RST;
			next_wakeCnt = '0;
			next_frameIgnored = 1'b0;
			next_transferFault = 1'b1;
		end
		next_chanOut = next_chanReg;
		if (next_state == PMRC_ST_FAILSAFE) begin
			next_chanOut[`PMRC_CHAN_A] = in1S;
			next_chanOut[`PMRC_CHAN_B] = in2S;
		end
		next_deviceOn = (next_state == PMRC_ST_OPERATE);
		next_failsafeActive = (next_state == PMRC_ST_FAILSAFE);
	end

	// Power-up reset lands in standby with defaults and the fault flag set.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= PMRC_ST_STANDBY;
			chanReg <= `PMRC_CHAN_RST;
			chanOut <= `PMRC_CHAN_RST;
			wakeCnt <= '0;
			transfer_fault_flag <= 1'b1;
			uvResetActive <= 1'b0;
			frameIgnored <= 1'b0;
			deviceOn <= 1'b0;
			failsafeActive <= 1'b0;
			togSeen <= 1'b0;
		end else begin
			state <= next_state;
			chanReg <= next_chanReg;
			chanOut <= next_chanOut;
			wakeCnt <= next_wakeCnt;
			transfer_fault_flag <= next_transferFault;
			uvResetActive <= next_uvReset;
			frameIgnored <= next_frameIgnored;
			deviceOn <= next_deviceOn;
			failsafeActive <= next_failsafeActive;
			togSeen <= pinSync[`PMRC_PIN_TOG];
		end
	end

	// ****************************************************************
	// Status word returned on the serial output
	// ****************************************************************

	pmrc_status_t status;

	// The word is registered before it crosses, so that the synchroniser on
	// the link clock never samples a glitch of the state decoding.
	always_comb begin
		status = '0;
		status.transferFault = transfer_fault_flag;
		status.failsafe = failsafeActive;
		status.operating = deviceOn;
		status.waking = (state == PMRC_ST_WAKEUP);
		status.uvReset = uvResetActive;
		status.frameIgnored = frameIgnored;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			statusSys <= '0;
		end else begin
			statusSys <= status;
		end
	end

endmodule // pmrc_power_mode_reset_control

`default_nettype wire

/* sim/pmrc_spi_host.sv */
/*
 * SPI host model: sends 16-bit frames MSB first on a 32 ns link clock.
 * Assumes go is pulsed only while busy is low.
 * The enabled serial output is captured at each falling clock edge.
 */
`default_nettype none

module pmrc_spi_host
	import pmrc_pkg::*;
(
	input wire logic go,
	input wire pmrc_frame_t frame,
	input wire logic spiSo,
	input wire logic spiSoOe,
	output logic spiClk,
	output logic spiCsN,
	output logic spiMosi,
	output logic busy,
	output logic [15:0] soWord
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{spiClk, spiMosi, busy} = 3'h0;
		spiCsN = 1'b1;
		soWord = 16'h0000;
	end
	// The clock stands low between frames and the released data line shows the inverse.
	always @(posedge go) begin
		busy = 1'b1;
		spiCsN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiMosi = frame[i];
			#16 spiClk = 1'b1;
			#16 soWord = {soWord[14:0], spiSo & spiSoOe};
			spiClk = 1'b0;
		end
		spiMosi = ~spiMosi;
		#16 spiCsN = 1'b1;
		#16 busy = 1'b0;
	end
endmodule // pmrc_spi_host

`default_nettype wire

/* sim/pmrc_ctl_chk.sv */
/*
 * Port checker of the power mode and reset controller, bound below.
 * Assumes a single clock domain reset by sys_rst.
 */
`default_nettype none

module pmrc_ctl_chk #(
	parameter int WAKEUP_CYCLES = 20
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic batteryUv,
	input wire logic logicUv,
	input wire logic failsafe_input,
	input wire logic directIn1,
	input wire logic spiCsN,
	input wire logic spiSoOe,
	input wire logic [7:0] chanOut,
	input wire logic deviceOn,
	input wire logic failsafeActive,
	input wire logic transfer_fault_flag,
	input wire logic uvResetActive
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_fs_held;
		failsafe_input [*5];
	endsequence
	sequence s_uv_clear;
		(!batteryUv && !logicUv) [*5];
	endsequence
	AST_FS_ON: assert property (s_fs_held |-> failsafeActive || uvResetActive)
		else $error("fail-safe not entered");
	AST_FS_CHAN: assert property (failsafeActive |-> (chanOut & 8'hE7) == 8'h00)
		else $error("fail-safe drives other channels");
	AST_FS_PIN: assert property ((failsafeActive && $stable(directIn1)) [*5] |-> chanOut[3] == directIn1)
		else $error("direct input not routed");
	AST_FS_OFF: assert property ($fell(failsafeActive) |-> !deviceOn && chanOut == 8'h00)
		else $error("fail-safe exit not to standby");
	AST_FS_CMD: assert property (failsafeActive |-> !deviceOn && transfer_fault_flag)
		else $error("operating during fail-safe");
	AST_UV_SET: assert property (batteryUv [*5] |-> uvResetActive)
		else $error("undervoltage reset missing");
	AST_UV_OUT: assert property (uvResetActive |-> chanOut == 8'h00 && !deviceOn && transfer_fault_flag)
		else $error("undervoltage reset outputs wrong");
	AST_UV_HOLD: assert property (uvResetActive && $past(logicUv, 2) |=> uvResetActive)
		else $error("undervoltage reset released early");
	AST_UV_REL: assert property (s_uv_clear |-> !uvResetActive)
		else $error("undervoltage reset not released");
	AST_STB: assert property ($fell(deviceOn) && !failsafeActive |-> chanOut == 8'h00)
		else $error("standby kept channels");
	AST_SO_OFF: assert property (spiCsN [*3] |-> !spiSoOe)
		else $error("serial output driven outside frame");
endmodule // pmrc_ctl_chk

bind pmrc_power_mode_reset_control pmrc_ctl_chk #(.WAKEUP_CYCLES(WAKEUP_CYCLES)) chk_i (.clock, .sys_rst,
	.batteryUv, .logicUv, .failsafe_input, .directIn1, .spiCsN, .spiSoOe, .chanOut, .deviceOn,
	.failsafeActive, .transfer_fault_flag, .uvResetActive);

`default_nettype wire

/* sim/pmrc_power_mode_reset_control_bench.sv */
/*
 * Self-checking bench of the power mode and reset controller.
 * Assumes the SPI host model and the bound checker are compiled with it.
 */
`default_nettype none

module pmrc_power_mode_reset_control_bench
	import pmrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WK = 100;
	logic clock, sys_rst, batteryUv, logicUv, failsafe_input, directIn1, directIn2, go, busy;
	logic spiClk, spiCsN, spiMosi, spiSo, spiSoOe, deviceOn, failsafeActive, transfer_fault_flag;
	logic uvResetActive, frameIgnored;
	logic [15:0] soWord;
	logic [7:0] chanOut, c;
	logic [25:0] e;
	logic [25:0] q[$];
	pmrc_frame_t frame;
	int error_cnt, compares, n;
	event chk;
	wire [12:0] obs = {deviceOn, failsafeActive, transfer_fault_flag, uvResetActive, frameIgnored, chanOut};

	pmrc_power_mode_reset_control #(.WAKEUP_CYCLES(WK)) uut (.clock, .sys_rst, .batteryUv, .logicUv,
		.failsafe_input, .directIn1, .directIn2, .spiClk, .spiCsN, .spiMosi, .spiSo, .spiSoOe, .chanOut,
		.deviceOn, .failsafeActive, .transfer_fault_flag, .uvResetActive, .frameIgnored);
	pmrc_spi_host host (.go, .frame, .spiSo, .spiSoOe, .spiClk, .spiCsN, .spiMosi, .busy, .soWord);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	function automatic logic [12:0] st(logic on, fs, fl, uv, ig, logic [7:0] ch);
		return {on, fs, fl, uv, ig, ch};
	endfunction
	task automatic check(logic [12:0] x, logic [12:0] m = 13'h1FFF);
		q.push_back({m, x});
		->chk;
	endtask
	// The watcher takes the oldest note whenever a result is announced.
	always @(chk) begin
		e = q.pop_front();
		compares++;
		if ((obs & e[25:13]) !== (e[12:0] & e[25:13])) begin
			error_cnt++;
			$display("ERROR status expected %h seen %h", e[12:0], obs);
		end
	end
	task automatic send(logic [15:0] v);
		frame = v;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (n = 0; n < 100 && busy; n++) tick(1);
		if (busy) begin
			error_cnt++;
			complete_run();
		end
		tick(8);
	endtask
	task automatic wake(logic poke);
		time t0;
		send(16'h0100);
		t0 = $time;
		if (poke) begin
			send({8'h00, 8'hFF});
			check(st(0, 0, 0, 0, 1, 8'h00));
		end
		for (n = 0; n < WK + 40 && deviceOn !== 1'b1; n++) tick(1);
		compares++;
		if ($time - t0 < WK * 5 || deviceOn !== 1'b1) begin
			error_cnt++;
			$display("ERROR wake time expected %0d seen %0d", WK * 10, $time - t0);
			if (deviceOn !== 1'b1) complete_run();
		end
	endtask

	initial begin
		{batteryUv, logicUv, failsafe_input, directIn1, directIn2, go} = 6'h00;
		frame = 16'h0000;
		sys_rst = 1'b1;
		c = 8'($urandom(32'h8A67));
		tick(12);
		sys_rst = 1'b0;
		tick(3);
		check(st(0, 0, 1, 0, 0, 8'h00));
		wake(1);
		c = 8'($urandom);
		send({8'h00, c});
		check(st(1, 0, 0, 0, 0, c));
		logicUv = 1'b1;
		tick(10);
		check(st(1, 0, 0, 0, 0, c));
		batteryUv = 1'b1;
		tick(6);
		check(st(0, 0, 1, 1, 0, 8'h00));
		send(16'h0100);
		send(16'h0100);
		compares++;
		if (soWord !== 16'h8800) begin
			error_cnt++;
			$display("ERROR status frame expected %h seen %h", 16'h8800, soWord);
		end
		batteryUv = 1'b0;
		tick(6);
		check(st(0, 0, 1, 1, 0, 8'h00));
		logicUv = 1'b0;
		tick(6);
		check(st(0, 0, 1, 0, 0, 8'h00));
		wake(0);
		send({8'h00, c});
		send(16'h0400);
		check(st(0, 0, 1, 0, 0, 8'h00));
		wake(0);
		send({8'h00, ~c});
		send(16'h0200);
		check(st(0, 0, 0, 0, 0, 8'h00));
		{directIn1, directIn2} = 2'($urandom);
		failsafe_input = 1'b1;
		tick(6);
		check(st(0, 1, 1, 0, 0, {3'h0, directIn2, directIn1, 3'h0}));
		send(16'h0500);
		check(st(0, 1, 1, 0, 1, {3'h0, directIn2, directIn1, 3'h0}));
		failsafe_input = 1'b0;
		tick(6);
		check(st(0, 0, 1, 0, 1, 8'h00));
		tick(2);
		complete_run();
	end
endmodule // pmrc_power_mode_reset_control_bench

`default_nettype wire
